// ===== shared/adcc_regs.svh
// register offsets, field positions, reset values and timing constants of the converter control
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

// register indices: the byte address is the index times four
`define ADCC_IDX_INTCTL 8'h0B
`define ADCC_IDX_PFLAG 8'h0C
`define ADCC_IDX_PADIR 8'h85
`define ADCC_IDX_PEN 8'h8C
`define ADCC_IDX_CTL0 8'h10
`define ADCC_IDX_CTL1 8'h11
`define ADCC_IDX_RESH 8'h12
`define ADCC_IDX_RESL 8'h13
`define ADCC_IDX_APSEL 8'h14
`define ADCC_IDX_ISTAT 8'hA0
`define ADCC_IDX_IMASK 8'hA1

// field positions
`define ADCC_CTL0_FMT 7
`define ADCC_CTL0_REF 6
`define ADCC_CTL0_CHS_HI 4
`define ADCC_CTL0_CHS_LO 2
`define ADCC_CTL0_GO 1
`define ADCC_CTL0_ON 0
`define ADCC_CTL1_CS_HI 6
`define ADCC_CTL1_CS_LO 4
`define ADCC_PFLAG_DONE 6
`define ADCC_INT_GLOBAL 7
`define ADCC_INT_PERIPH 6

// reset values
`define ADCC_RST_PADIR 8'h3F
`define ADCC_RST_ZERO 8'h00

// conversion timing in conversion clock periods
`define ADCC_CONV_TADS 4'd11
`define ADCC_ABORT_TADS 4'd2
`define ADCC_RES_BITS 10
// rc clock: nominal 4 us period at 100 MHz
`define ADCC_RC_PERIOD_NS 4000
`define ADCC_CLK_PERIOD_NS 10
`endif

// ===== shared/adcc_pkg.sv
// types shared by the converter control block
package adcc_pkg;
    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_CONV,
        ADCC_ABORT_WAIT
    } adcc_state_t;

    typedef struct packed {
        logic [2:0] channel;
        logic ref_ext;
        logic sample;
        logic enable;
    } adcc_analog_t;

    typedef struct packed {
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [9:0] haddr;
    } adcc_ahb_addr_t;
endpackage

// ===== hdl/adcc_tad_gen.sv
// conversion clock enable generator: oscillator divider or rc rate
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_tad_gen
    import adcc_pkg::*;
#(
    parameter int RC_DIV = `ADCC_RC_PERIOD_NS / `ADCC_CLK_PERIOD_NS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // control
    input wire logic run_i,
    input wire logic [2:0] sel_i,
    // one-cycle enable per conversion clock period
    output logic tad_o
);
    logic [11:0] cnt_r;
    logic [11:0] limit;
    // 000:2 100:4 001:8 101:16 010:32 110:64 x11:rc
    assign limit = (sel_i[1:0] == 2'b11) ? 12'(RC_DIV - 1) :
                   12'((12'h002 << {sel_i[1:0], sel_i[2]}) - 12'h001);
    assign tad_o = run_i && (cnt_r >= limit);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= 12'h000;
        end else if (!run_i || tad_o) begin
            cnt_r <= 12'h000;
        end else begin
            cnt_r <= cnt_r + 12'h001;
        end
    end

    a_tad_period_min: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        tad_o |=> !tad_o)
        else $error("conversion clock enable repeated too soon");
endmodule

// ===== hdl/adcc_top.sv
// converter control block with ahb-lite register slave
// Summary of operation
// - successive approximation yields a 10-bit result stored in the result pair
// - channel select bits 4:2 of control 0 pick one of eight inputs
// - control 0 bit 6 picks external reference when set, supply when clear
// - one conversion lasts eleven conversion clock periods
// - control 1 bits 6:4 pick divide 2..64 or the rc clock
// - writing one to the go bit starts; it reads one while converting
// - on completion clear go, set done flag bit 6, interrupt if enabled
// - clearing go mid-conversion aborts; result keeps the previous value
// - after abort wait two periods, then acquire the selected channel
// - analog select bits kill input buffers; direction bits tristate drivers
// - control 0 bit 7 picks right justification when set, left when clear
// - control 0 bit 0 powers the converter; clear shuts it off
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_top
    import adcc_pkg::*;
#(
    parameter int RES_BITS = `ADCC_RES_BITS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [9:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // analog front end
    output adcc_analog_t analog_o,
    input wire logic comp_i,
    // port pins
    output logic [7:0] pin_buf_disable_o,
    output logic [7:0] pin_drv_hiz_o,
    // interrupt
    output logic irq_o,
    output logic adc_irq_o
);
    logic [7:0] ctl0_r, ctl1_r, apsel_r, padir_r, intctl_r, pen_r, pflag_r;
    logic [7:0] istat_r, imask_r;
    logic [RES_BITS-1:0] result_r, sar_r, trial;
    logic [3:0] tad_cnt_r;
    logic [3:0] bit_idx_r;
    logic comp_s1_r, comp_s2_r, comp_s3_r;
    adcc_state_t state_r, state_nxt;
    logic tad;
    logic restart_r;
    logic done_ev, abort_ev, start_ev;

    // ahb address phase capture
    logic wr_pend_r, rd_pend_r;
    logic [7:0] idx_r;
    logic accept;
    logic [7:0] wdata;
    assign accept = hsel_i && hready_i && htrans_i[1];
    assign wdata = hwdata_i[7:0];
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            idx_r <= 8'h00;
        end else begin
            wr_pend_r <= accept && hwrite_i;
            rd_pend_r <= accept && !hwrite_i;
            if (accept) begin
                idx_r <= haddr_i[9:2];
            end
        end
    end

    logic wr_ctl0, wr_ctl1, wr_apsel, wr_padir, wr_int, wr_pen, wr_pflag, wr_istat, wr_imask;
    assign wr_ctl0 = wr_pend_r && (idx_r == `ADCC_IDX_CTL0);
    assign wr_ctl1 = wr_pend_r && (idx_r == `ADCC_IDX_CTL1);
    assign wr_apsel = wr_pend_r && (idx_r == `ADCC_IDX_APSEL);
    assign wr_padir = wr_pend_r && (idx_r == `ADCC_IDX_PADIR);
    assign wr_int = wr_pend_r && (idx_r == `ADCC_IDX_INTCTL);
    assign wr_pen = wr_pend_r && (idx_r == `ADCC_IDX_PEN);
    assign wr_pflag = wr_pend_r && (idx_r == `ADCC_IDX_PFLAG);
    assign wr_istat = wr_pend_r && (idx_r == `ADCC_IDX_ISTAT);
    assign wr_imask = wr_pend_r && (idx_r == `ADCC_IDX_IMASK);

    // go written one while enabled and idle starts; written zero mid-conversion aborts
    logic conv_on;
    assign conv_on = ctl0_r[`ADCC_CTL0_ON];
    assign start_ev = wr_ctl0 && wdata[`ADCC_CTL0_GO] && conv_on && wdata[`ADCC_CTL0_ON]
                      && (state_r == ADCC_IDLE);
    assign abort_ev = (state_r == ADCC_CONV) &&
                      ((wr_ctl0 && !wdata[`ADCC_CTL0_GO]) || !conv_on);

    // conversion clock enable
    adcc_tad_gen u_tad (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .run_i((state_r != ADCC_IDLE) && !restart_r),
        .sel_i(ctl1_r[`ADCC_CTL1_CS_HI:`ADCC_CTL1_CS_LO]),
        .tad_o(tad)
    );

    // comparator bit from the analog side, three-stage synchroniser;
    // the held value follows only once the second and third stage agree
    logic comp_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            comp_s1_r <= 1'b0;
            comp_s2_r <= 1'b0;
            comp_s3_r <= 1'b0;
            comp_r <= 1'b0;
        end else begin
            comp_s1_r <= comp_i;
            comp_s2_r <= comp_s1_r;
            comp_s3_r <= comp_s2_r;
            if (comp_s2_r == comp_s3_r) begin
                comp_r <= comp_s3_r;
            end
        end
    end
    logic comp_bit;
    assign comp_bit = comp_r;

    // state machine: one sample period, ten bit trials = eleven periods
    assign done_ev = (state_r == ADCC_CONV) && tad && (tad_cnt_r == `ADCC_CONV_TADS - 4'd1)
                     && !abort_ev;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ADCC_IDLE: begin
                if (start_ev) begin
                    state_nxt = ADCC_CONV;
                end
            end
            ADCC_CONV: begin
                if (abort_ev) begin
                    state_nxt = ADCC_ABORT_WAIT;
                end else if (done_ev) begin
                    state_nxt = ADCC_IDLE;
                end
            end
            ADCC_ABORT_WAIT: begin
                if (tad && tad_cnt_r == `ADCC_ABORT_TADS - 4'd1) begin
                    state_nxt = ADCC_IDLE;
                end
            end
            default: state_nxt = ADCC_IDLE;
        endcase
    end

    // successive approximation trial word
    assign trial = sar_r | (RES_BITS'(1) << bit_idx_r);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= ADCC_IDLE;
            restart_r <= 1'b0;
            tad_cnt_r <= 4'h0;
            bit_idx_r <= 4'h0;
            sar_r <= '0;
            result_r <= '0;
        end else begin
            state_r <= state_nxt;
            // divider restarts on each state change so every phase gets whole periods
            restart_r <= (state_r != state_nxt);
            if (state_r != state_nxt) begin
                tad_cnt_r <= 4'h0;
                bit_idx_r <= 4'(RES_BITS - 1);
                sar_r <= '0;
            end else if (tad) begin
                tad_cnt_r <= tad_cnt_r + 4'h1;
                if (state_r == ADCC_CONV && tad_cnt_r != 4'h0) begin
                    sar_r <= comp_bit ? trial : sar_r;
                    bit_idx_r <= bit_idx_r - 4'h1;
                end
            end
            if (done_ev) begin
                result_r <= comp_bit ? trial : sar_r;
            end
        end
    end

    // control registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl0_r <= `ADCC_RST_ZERO;
            ctl1_r <= `ADCC_RST_ZERO;
            apsel_r <= `ADCC_RST_ZERO;
            padir_r <= `ADCC_RST_PADIR;
            intctl_r <= `ADCC_RST_ZERO;
            pen_r <= `ADCC_RST_ZERO;
            imask_r <= `ADCC_RST_ZERO;
        end else begin
            if (wr_ctl0) begin
                // go stays set when rewritten as one mid-conversion
                ctl0_r <= {wdata[7:6], 1'b0, wdata[4:2],
                           start_ev || (ctl0_r[`ADCC_CTL0_GO] && wdata[`ADCC_CTL0_GO] && !done_ev),
                           wdata[0]};
            end else if (done_ev || abort_ev) begin
                ctl0_r[`ADCC_CTL0_GO] <= 1'b0;
            end
            if (wr_ctl1) begin
                ctl1_r <= {1'b0, wdata[6:4], 4'h0};
            end
            if (wr_apsel) begin
                apsel_r <= wdata;
            end
            if (wr_padir) begin
                padir_r <= {2'b00, wdata[5:0]};
            end
            if (wr_int) begin
                intctl_r <= wdata;
            end
            if (wr_pen) begin
                pen_r <= wdata;
            end
            if (wr_imask) begin
                imask_r <= wdata;
            end
        end
    end

    // done flag: hardware set wins over software write
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pflag_r <= `ADCC_RST_ZERO;
            istat_r <= `ADCC_RST_ZERO;
        end else begin
            if (wr_pflag) begin
                pflag_r <= wdata;
            end
            if (done_ev) begin
                pflag_r[`ADCC_PFLAG_DONE] <= 1'b1;
            end
            istat_r <= (istat_r & ~(wr_istat ? wdata : 8'h00)) |
                       {1'b0, done_ev, 6'h00};
        end
    end

    // interrupt gating
    assign adc_irq_o = pflag_r[`ADCC_PFLAG_DONE] && pen_r[`ADCC_PFLAG_DONE] &&
                       intctl_r[`ADCC_INT_PERIPH] && intctl_r[`ADCC_INT_GLOBAL];
    assign irq_o = |(istat_r & imask_r);

    // analog front end
    assign analog_o.channel = ctl0_r[`ADCC_CTL0_CHS_HI:`ADCC_CTL0_CHS_LO];
    assign analog_o.ref_ext = ctl0_r[`ADCC_CTL0_REF];
    assign analog_o.sample = conv_on && (state_r == ADCC_IDLE);
    assign analog_o.enable = conv_on;
    assign pin_buf_disable_o = apsel_r;
    assign pin_drv_hiz_o = padir_r;

    // result justification
    logic [7:0] res_hi, res_lo;
    assign res_hi = ctl0_r[`ADCC_CTL0_FMT] ? {6'h00, result_r[9:8]} : result_r[9:2];
    assign res_lo = ctl0_r[`ADCC_CTL0_FMT] ? result_r[7:0] : {result_r[1:0], 6'h00};

    logic [7:0] rd_mux;
    assign rd_mux = (idx_r == `ADCC_IDX_CTL0) ? ctl0_r :
                    (idx_r == `ADCC_IDX_CTL1) ? ctl1_r :
                    (idx_r == `ADCC_IDX_APSEL) ? apsel_r :
                    (idx_r == `ADCC_IDX_PADIR) ? padir_r :
                    (idx_r == `ADCC_IDX_INTCTL) ? intctl_r :
                    (idx_r == `ADCC_IDX_PEN) ? pen_r :
                    (idx_r == `ADCC_IDX_PFLAG) ? pflag_r :
                    (idx_r == `ADCC_IDX_RESH) ? res_hi :
                    (idx_r == `ADCC_IDX_RESL) ? res_lo :
                    (idx_r == `ADCC_IDX_ISTAT) ? istat_r :
                    (idx_r == `ADCC_IDX_IMASK) ? imask_r : 8'h00;
    assign hrdata_o = rd_pend_r ? {24'h000000, rd_mux} : 32'h00000000;

    // assertions
    int unsigned conv_len_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            conv_len_r <= 0;
        end else if (state_r == ADCC_CONV) begin
            conv_len_r <= conv_len_r + (tad ? 1 : 0);
        end else begin
            conv_len_r <= 0;
        end
    end

    a_conv_eleven: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        done_ev |-> conv_len_r == 10)
        else $error("conversion did not last eleven periods");
    a_done_sets_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        done_ev |=> pflag_r[`ADCC_PFLAG_DONE] && !ctl0_r[`ADCC_CTL0_GO])
        else $error("completion did not set flag and clear go");
    a_abort_keeps_res: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        abort_ev |=> $stable(result_r))
        else $error("abort changed the result");
    a_abort_wait: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        abort_ev |=> !analog_o.sample [*2])
        else $error("acquisition restarted too soon after abort");
    a_go_reads_one: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        start_ev |=> ctl0_r[`ADCC_CTL0_GO] && state_r == ADCC_CONV)
        else $error("go bit not set during conversion");
    a_irq_gating: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        adc_irq_o |-> intctl_r[`ADCC_INT_GLOBAL] && pen_r[`ADCC_PFLAG_DONE])
        else $error("interrupt raised while disabled");
    a_off_no_conv: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !conv_on |=> state_r != ADCC_CONV)
        else $error("converter running while off");
    a_right_just: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ctl0_r[`ADCC_CTL0_FMT] |-> {res_hi, res_lo} == {6'h00, result_r})
        else $error("right justified result misplaced");
    a_left_just: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !ctl0_r[`ADCC_CTL0_FMT] |-> {res_hi, res_lo} == {result_r, 6'h00})
        else $error("left justified result misplaced");
    a_chan_route: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_ctl0 |=> analog_o.channel == $past(wdata[4:2]))
        else $error("channel select not routed");

    c_conv_done: cover property (@(posedge clk_i) done_ev);
    c_abort: cover property (@(posedge clk_i) abort_ev);
    c_irq: cover property (@(posedge clk_i) adc_irq_o && irq_o);
endmodule

// ===== sim/adcc_analog_model.sv
// analog front end model: comparator answering from the selected channel and reference
`timescale 1ns/1ps
module adcc_analog_model
    import adcc_pkg::*;
(
    // clock
    input wire logic clk_i,
    // from the converter control
    input wire adcc_analog_t analog_i,
    // comparator result
    output logic comp_o
);
    logic toggle_r = 1'b0;
    always @(posedge clk_i) begin
        toggle_r <= ~toggle_r;
    end
    // odd channels and the external reference sit above every trial level
    // a powered-down front end gives no steady answer
    // the comparator settles within a cycle, so every divider and the rc clock convert exactly
    assign comp_o = analog_i.enable ? (analog_i.channel[0] | analog_i.ref_ext) : toggle_r;
endmodule

// ===== sim/adcc_top_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_top_tb
    import adcc_pkg::*;
;
    logic clk_i, reset_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, comp_i, irq_o, adc_irq_o;
    logic [9:0] haddr_i;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    logic [31:0] hwdata_i, hrdata_o, rd, rd_smp;
    logic rdy_smp;
    logic [7:0] pin_buf_disable_o, pin_drv_hiz_o, r8, c0;
    logic [9:0] last_res;
    adcc_analog_t analog_o;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc_cnt = 0;
    int n;
    int div_tab[8] = '{2, 8, 32, 400, 4, 16, 64, 400};
    logic [9:0] exp_q[$];

    adcc_top adcc_top_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .analog_o(analog_o), .comp_i(comp_i),
        .pin_buf_disable_o(pin_buf_disable_o), .pin_drv_hiz_o(pin_drv_hiz_o), .irq_o(irq_o),
        .adc_irq_o(adc_irq_o));
    adcc_analog_model adcc_analog_model_i (.clk_i(clk_i), .analog_i(analog_o), .comp_o(comp_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        rd_smp <= hrdata_o;
        rdy_smp <= hreadyout_o;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // one single-word transfer; read data lands in rd
    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        haddr_i <= {idx, 2'b00};
        htrans_i <= 2'b10;
        hwrite_i <= wr;
        hsize_i <= 3'b010;
        do begin @(posedge clk_i); #1; end while (rdy_smp !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        do begin @(posedge clk_i); #1; end while (rdy_smp !== 1'b1);
        rd = rd_smp;
    endtask

    task automatic conv(input logic [2:0] cs, input logic [2:0] ch, input logic rf,
                        input logic fm);
        int t0;
        logic [9:0] res;
        c0 = {fm, rf, 1'b0, ch, 2'b01};
        ahb(1'b1, `ADCC_IDX_CTL1, {25'h0, cs, 4'h0});
        ahb(1'b1, `ADCC_IDX_CTL0, {24'h0, c0});
        ahb(1'b1, `ADCC_IDX_CTL0, {24'h0, c0 | 8'h02});
        t0 = cyc_cnt;
        exp_q.push_back((ch[0] | rf) ? 10'h3FF : 10'h000);
        ahb(1'b0, `ADCC_IDX_CTL0, 32'h0);
        check(rd[1], 1'b1);
        while (rd[1] === 1'b1) ahb(1'b0, `ADCC_IDX_CTL0, 32'h0);
        n = cyc_cnt - t0;
        check(n >= 10 * div_tab[cs] && n <= 12 * div_tab[cs] + 12, 1'b1);
        res = exp_q.pop_front();
        last_res = res;
        ahb(1'b0, `ADCC_IDX_RESH, 32'h0);
        check(rd, fm ? {30'h0, res[9:8]} : {24'h0, res[9:2]});
        ahb(1'b0, `ADCC_IDX_RESL, 32'h0);
        check(rd, fm ? {24'h0, res[7:0]} : {24'h0, res[1:0], 6'h0});
        ahb(1'b0, `ADCC_IDX_PFLAG, 32'h0);
        check(rd[6], 1'b1);
    endtask

    initial begin
        #(30000 * 10);
        error_cnt++;
        end_sim();
    end

    initial begin
        reset_n_i = 1'b0;
        {hsel_i, hwrite_i, haddr_i, htrans_i, hwdata_i} = '0;
        hsize_i = 3'b010;
        void'($urandom(32'h1088b754));
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        // reset values, pin controls, unmapped place
        ahb(1'b0, `ADCC_IDX_INTCTL, 32'h0);
        check(rd, 32'h0);
        ahb(1'b0, `ADCC_IDX_PFLAG, 32'h0);
        check(rd, 32'h0);
        ahb(1'b0, `ADCC_IDX_PEN, 32'h0);
        check(rd, 32'h0);
        ahb(1'b0, `ADCC_IDX_PADIR, 32'h0);
        check(rd, {24'h0, `ADCC_RST_PADIR});
        check(pin_drv_hiz_o, 8'h3F);
        check({hreadyout_o, hresp_o}, 2'b10);
        ahb(1'b1, 8'h50, 32'hFF);
        ahb(1'b0, 8'h50, 32'h0);
        check(rd, 32'h0);
        r8 = 8'($urandom);
        ahb(1'b1, `ADCC_IDX_PADIR, {24'h0, r8});
        check(pin_drv_hiz_o, {2'b00, r8[5:0]});
        r8 = ~r8;
        ahb(1'b1, `ADCC_IDX_APSEL, {24'h0, r8});
        check(pin_buf_disable_o, r8);
        ahb(1'b0, `ADCC_IDX_APSEL, 32'h0);
        check(rd, {24'h0, r8});
        $display("test registers done");
        for (int ch = 0; ch < 8; ch++) begin
            c0 = {1'b0, ch[0] ^ ch[1], 1'b0, ch[2:0], 2'b01};
            ahb(1'b1, `ADCC_IDX_CTL0, {24'h0, c0});
            check({analog_o.channel, analog_o.ref_ext}, {ch[2:0], c0[6]});
            check({analog_o.enable, analog_o.sample}, 2'b11);
        end
        ahb(1'b1, `ADCC_IDX_CTL0, 32'h0);
        check(analog_o.enable, 1'b0);
        ahb(1'b1, `ADCC_IDX_CTL0, 32'h03);
        ahb(1'b0, `ADCC_IDX_CTL0, 32'h0);
        check(rd, 32'h01);
        $display("test selection done");
        for (int cs = 0; cs < 8; cs++) begin
            conv(cs[2:0], 3'($urandom), 1'($urandom), cs[0]);
            ahb(1'b1, `ADCC_IDX_PFLAG, 32'h0);
            ahb(1'b1, `ADCC_IDX_ISTAT, 32'h40);
        end
        $display("test conversions done");
        c0 = {1'b1, 1'b0, 1'b0, 2'b00, last_res == 10'h0, 2'b01};
        ahb(1'b1, `ADCC_IDX_CTL1, 32'h60);
        ahb(1'b1, `ADCC_IDX_CTL0, {24'h0, c0 | 8'h02});
        repeat (100) @(posedge clk_i);
        check(analog_o.sample, 1'b0);
        ahb(1'b1, `ADCC_IDX_CTL0, {24'h0, c0 | 8'h02});
        ahb(1'b0, `ADCC_IDX_CTL0, 32'h0);
        check(rd[1], 1'b1);
        ahb(1'b1, `ADCC_IDX_CTL0, {24'h0, c0});
        check(analog_o.sample, 1'b0);
        n = 0;
        while (analog_o.sample !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check(n >= 2 * 64 && n <= 2 * 64 + 4, 1'b1);
        ahb(1'b0, `ADCC_IDX_CTL0, 32'h0);
        check(rd[1], 1'b0);
        ahb(1'b0, `ADCC_IDX_RESH, 32'h0);
        check(rd, {30'h0, last_res[9:8]});
        ahb(1'b0, `ADCC_IDX_RESL, 32'h0);
        check(rd, {24'h0, last_res[7:0]});
        ahb(1'b0, `ADCC_IDX_PFLAG, 32'h0);
        check(rd[6], 1'b0);
        $display("test abort done");
        conv(3'b000, 3'd1, 1'b0, 1'b1);
        check(irq_o, 1'b0);
        ahb(1'b1, `ADCC_IDX_IMASK, 32'h40);
        check(irq_o, 1'b1);
        ahb(1'b1, `ADCC_IDX_ISTAT, 32'h40);
        check(irq_o, 1'b0);
        ahb(1'b1, `ADCC_IDX_PEN, 32'h40);
        ahb(1'b1, `ADCC_IDX_INTCTL, 32'h40);
        check(adc_irq_o, 1'b0);
        ahb(1'b1, `ADCC_IDX_INTCTL, 32'hC0);
        check(adc_irq_o, 1'b1);
        ahb(1'b1, `ADCC_IDX_PFLAG, 32'h0);
        check(adc_irq_o, 1'b0);
        $display("test interrupts done");
        end_sim();
    end
endmodule
